// ==== src/rhgs_top.sv ====
// Root hub global status and power control core with its bus front end
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rhgs_params.svh"

module rhgs_top #(
    parameter int NUM_PORTS = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite register port
    input wire logic [`RHGS_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`RHGS_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Configuration from the descriptor registers
    input wire logic switching_mode_select,
    input wire logic [`RHGS_MASK_W-1:0] port_power_mask,
    input wire logic overcurrent_per_port,
    // Root hub side
    input wire logic overcurrent_field,
    input wire logic [`RHGS_MASK_W-1:0] connect_status_change,
    input wire logic bus_suspended,
    output logic resume_request,
    output logic [`RHGS_MASK_W-1:0] port_power_status,
    output logic irq
);

    // ---------------------------------------------------------------
    // Bus front end and over-current synchroniser
    // ---------------------------------------------------------------
    rhgs_reg_if regs ();

    rhgs_axi_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .regs(regs)
    );

    logic oc_level;

    // The over-current pin comes from the port power switches, not this clock
    rhgs_sync u_oc_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(overcurrent_field),
        .level(oc_level)
    );

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    // Word match on the upper address bits; byte offset bits are ignored
    function automatic logic reg_hit(
        input logic [`RHGS_ADDR_W-1:0] addr,
        input logic [`RHGS_ADDR_W-1:0] offset
    );
        reg_hit = (addr[`RHGS_ADDR_W-1:2] == offset[`RHGS_ADDR_W-1:2]);
    endfunction

    // Expand byte enables so a lane that is not written carries zeros
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    logic wr_hub;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic [31:0] wr_bits;

    assign wr_bits = regs.wr_data & lane_mask(regs.wr_strb);
    assign wr_hub = regs.wr_en && reg_hit(regs.wr_addr, `RHGS_OFF_HUB_STATUS);
    assign wr_irq_status = regs.wr_en && reg_hit(regs.wr_addr, `RHGS_OFF_IRQ_STATUS);
    assign wr_irq_mask = regs.wr_en && reg_hit(regs.wr_addr, `RHGS_OFF_IRQ_MASK);

    // Writes to the port status words are accepted and dropped
    assign regs.wr_err = !(reg_hit(regs.wr_addr, `RHGS_OFF_HUB_STATUS)
        || reg_hit(regs.wr_addr, `RHGS_OFF_PORT_FIRST)
        || reg_hit(regs.wr_addr, `RHGS_OFF_PORT_SECOND)
        || reg_hit(regs.wr_addr, `RHGS_OFF_IRQ_STATUS)
        || reg_hit(regs.wr_addr, `RHGS_OFF_IRQ_MASK)
        || reg_hit(regs.wr_addr, `RHGS_OFF_PORT_POWER));

    // ---------------------------------------------------------------
    // Command decode from the hub status word
    // ---------------------------------------------------------------
    // Only bits that software writes as one act; reserved bits are expected zero
    logic cmd_wake_set;
    logic cmd_wake_clr;
    logic cmd_power_on;
    logic cmd_power_off;
    logic cmd_oc_ack;

    assign cmd_wake_set = wr_hub && wr_bits[`RHGS_BIT_WAKE];
    assign cmd_wake_clr = wr_hub && wr_bits[`RHGS_BIT_WAKE_CLR];
    assign cmd_power_on = wr_hub && wr_bits[`RHGS_BIT_LOCAL_CHG];
    assign cmd_power_off = wr_hub && wr_bits[`RHGS_BIT_LOCAL_POWER];
    assign cmd_oc_ack = wr_hub && wr_bits[`RHGS_BIT_OC_CHG];

    // Ports that a global power command reaches in the present mode
    logic [`RHGS_MASK_W-1:0] power_target;

    genvar gp;
    generate
        for (gp = 0; gp < `RHGS_MASK_W; gp++) begin : g_target
            if (gp >= 1 && gp <= NUM_PORTS) begin : g_port
                // Mode zero ganged, mode one only ports with a clear mask bit
                assign power_target[gp] = !switching_mode_select
                    || !port_power_mask[gp];
            end else begin : g_none
                // Bit 0 of the mask is reserved and absent ports never power
                assign power_target[gp] = 1'b0;
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Events
    // ---------------------------------------------------------------
    rhgs_pkg::rhgs_core_t c_reg;
    rhgs_pkg::rhgs_core_t c_next;
    logic oc_reported;
    logic oc_changed;
    logic resume_event;

    // Per-port reporting keeps the global indicator at zero
    assign oc_reported = overcurrent_per_port ? 1'b0 : oc_level;
    assign oc_changed = (oc_reported != c_reg.oc_indicator);

    // Connect change counts as a wake only while enabled and suspended
    assign resume_event = c_reg.wake_enable && bus_suspended
        && (|connect_status_change);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        c_next = c_reg;
        c_next.oc_indicator = oc_reported;
        c_next.resume_pulse = resume_event;

        // Clear is evaluated last so it beats a set in the same write
        if (cmd_wake_set) begin
            c_next.wake_enable = 1'b1;
        end
        if (cmd_wake_clr) begin
            c_next.wake_enable = 1'b0;
        end

        // A fresh change beats an acknowledge in the same cycle
        if (cmd_oc_ack) begin
            c_next.oc_change = 1'b0;
        end
        if (oc_changed) begin
            c_next.oc_change = 1'b1;
        end

        // Power on first, then power off, so an on-and-off write leaves ports off
        if (cmd_power_on) begin
            c_next.port_power = c_reg.port_power | power_target;
        end
        if (cmd_power_off) begin
            c_next.port_power = c_next.port_power & ~power_target;
        end

        // Interrupt mask and sticky status, write one to clear
        if (wr_irq_mask) begin
            c_next.irq_mask = wr_bits[`RHGS_IRQ_W-1:0];
        end
        if (wr_irq_status) begin
            c_next.irq_status = c_reg.irq_status & ~wr_bits[`RHGS_IRQ_W-1:0];
        end
        if (oc_changed) begin
            c_next.irq_status[`RHGS_IRQ_OC] = 1'b1;
        end
        if (resume_event) begin
            c_next.irq_status[`RHGS_IRQ_RESUME] = 1'b1;
        end
    end

    // Single state register; everything clears to zero at reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c_reg <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    // ---------------------------------------------------------------
    // Read back
    // ---------------------------------------------------------------
    // Status in the low half-word, change bits in the high half
    logic [31:0] hub_word;

    always_comb begin
        hub_word = `RHGS_RESET_WORD;
        hub_word[`RHGS_BIT_OC_IND] = c_reg.oc_indicator;
        hub_word[`RHGS_BIT_WAKE] = c_reg.wake_enable;
        hub_word[`RHGS_BIT_OC_CHG] = c_reg.oc_change;
        // Local power and its change bit are unsupported and stay zero
        hub_word[`RHGS_BIT_LOCAL_POWER] = 1'b0;
        hub_word[`RHGS_BIT_LOCAL_CHG] = 1'b0;
    end

    // Read mux; the slave registers the result on the address handshake
    always_comb begin
        regs.rd_data = `RHGS_RESET_WORD;
        regs.rd_err = 1'b0;
        if (reg_hit(regs.rd_addr, `RHGS_OFF_HUB_STATUS)) begin
            regs.rd_data = hub_word;
        end else if (reg_hit(regs.rd_addr, `RHGS_OFF_PORT_FIRST)
            || reg_hit(regs.rd_addr, `RHGS_OFF_PORT_SECOND)) begin
            // Per-port status lives elsewhere; these words read as zero here
            regs.rd_data = `RHGS_RESET_WORD;
        end else if (reg_hit(regs.rd_addr, `RHGS_OFF_IRQ_STATUS)) begin
            regs.rd_data[`RHGS_IRQ_W-1:0] = c_reg.irq_status;
        end else if (reg_hit(regs.rd_addr, `RHGS_OFF_IRQ_MASK)) begin
            regs.rd_data[`RHGS_IRQ_W-1:0] = c_reg.irq_mask;
        end else if (reg_hit(regs.rd_addr, `RHGS_OFF_PORT_POWER)) begin
            regs.rd_data[`RHGS_MASK_W-1:0] = c_reg.port_power;
        end else begin
            regs.rd_err = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign port_power_status = c_reg.port_power;
    assign resume_request = c_reg.resume_pulse;
    assign irq = |(c_reg.irq_status & c_reg.irq_mask);

endmodule

`default_nettype wire

// ==== src/rhgs_params.svh ====
// Constants for the root hub global status block: offsets, bit positions, reset values
`ifndef RHGS_PARAMS_SVH
`define RHGS_PARAMS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define RHGS_ADDR_W 8
`define RHGS_OFF_HUB_STATUS 8'h50
`define RHGS_OFF_PORT_FIRST 8'h54
`define RHGS_OFF_PORT_SECOND 8'h58
`define RHGS_OFF_IRQ_STATUS 8'h60
`define RHGS_OFF_IRQ_MASK 8'h64
`define RHGS_OFF_PORT_POWER 8'h68
`define RHGS_RESET_WORD 32'h0000_0000

// ---------------------------------------------------------------
// Hub status word fields
// ---------------------------------------------------------------
`define RHGS_BIT_LOCAL_POWER 0
`define RHGS_BIT_OC_IND 1
`define RHGS_BIT_WAKE 15
`define RHGS_BIT_LOCAL_CHG 16
`define RHGS_BIT_OC_CHG 17
`define RHGS_BIT_WAKE_CLR 31

// ---------------------------------------------------------------
// Interrupt status and mask fields
// ---------------------------------------------------------------
`define RHGS_IRQ_OC 0
`define RHGS_IRQ_RESUME 1
`define RHGS_IRQ_W 2

// ---------------------------------------------------------------
// Bus answers and widths
// ---------------------------------------------------------------
`define RHGS_RESP_OKAY 2'h0
`define RHGS_RESP_SLVERR 2'h2
`define RHGS_MASK_W 16

`endif

// ==== src/rhgs_pkg.sv ====
// Types shared by the root hub global status modules
`include "rhgs_params.svh"

package rhgs_pkg;

    // Core state: wake, over-current, interrupts, port power
    typedef struct packed {
        logic wake_enable;
        logic oc_indicator;
        logic oc_change;
        logic [`RHGS_IRQ_W-1:0] irq_status;
        logic [`RHGS_IRQ_W-1:0] irq_mask;
        logic [`RHGS_MASK_W-1:0] port_power;
        logic resume_pulse;
    } rhgs_core_t;

    // Bus slave state
    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [`RHGS_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } rhgs_slave_t;

    // Three-stage synchroniser state
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } rhgs_sync_t;

endpackage

// ==== src/rhgs_reg_if.sv ====
// Register access carrier between the bus slave and the status core
`timescale 1ns/1ns
`default_nettype none
`include "rhgs_params.svh"

interface rhgs_reg_if;
    logic wr_en;
    logic [`RHGS_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [`RHGS_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    modport slave (
        output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        input wr_err, rd_data, rd_err
    );
    modport core (
        input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        output wr_err, rd_data, rd_err
    );
endinterface

`default_nettype wire

// ==== src/rhgs_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
`default_nettype none

module rhgs_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic level
);
    rhgs_pkg::rhgs_sync_t state_reg;
    rhgs_pkg::rhgs_sync_t state_next;

    // Shift chain; the level moves only once stages two and three agree
    always_comb begin
        state_next = state_reg;
        state_next.ff1 = async_in;
        state_next.ff2 = state_reg.ff1;
        state_next.ff3 = state_reg.ff2;
        if (state_reg.ff2 == state_reg.ff3) begin
            state_next.level = state_reg.ff3;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.level;
endmodule

`default_nettype wire

// ==== src/rhgs_axi_slave.sv ====
// AXI4-Lite slave front end for the root hub global status registers
`timescale 1ns/1ns
`default_nettype none
`include "rhgs_params.svh"

module rhgs_axi_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`RHGS_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`RHGS_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    rhgs_reg_if.slave regs
);
    rhgs_pkg::rhgs_slave_t s_reg;
    rhgs_pkg::rhgs_slave_t s_next;
    logic aw_take;
    logic w_take;
    logic do_write;

    // Address and data are accepted in either order and held until both are in
    assign awready = !s_reg.aw_held && !s_reg.bvalid;
    assign wready = !s_reg.w_held && !s_reg.bvalid;
    assign arready = !s_reg.rvalid;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign do_write = (s_reg.aw_held || aw_take) && (s_reg.w_held || w_take);

    // Write strobe to the core; a held item wins over the live bus
    assign regs.wr_en = do_write;
    assign regs.wr_addr = s_reg.aw_held ? s_reg.awaddr : awaddr;
    assign regs.wr_data = s_reg.w_held ? s_reg.wdata : wdata;
    assign regs.wr_strb = s_reg.w_held ? s_reg.wstrb : wstrb;
    assign regs.rd_addr = araddr;

    // Channel bookkeeping
    always_comb begin
        s_next = s_reg;
        if (aw_take) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr = awaddr;
        end
        if (w_take) begin
            s_next.w_held = 1'b1;
            s_next.wdata = wdata;
            s_next.wstrb = wstrb;
        end
        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = regs.wr_err ? `RHGS_RESP_SLVERR : `RHGS_RESP_OKAY;
        end else if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        // Read data is captured on the address handshake, so it never glitches
        if (arvalid && arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = regs.rd_data;
            s_next.rresp = regs.rd_err ? `RHGS_RESP_SLVERR : `RHGS_RESP_OKAY;
        end else if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
endmodule

`default_nettype wire

// ==== verification/rhgs_sva.sv ====
// Port-level checker for the root hub global status block
`timescale 1ns/1ns
`default_nettype none
`include "rhgs_params.svh"

module rhgs_sva #(
    parameter int NUM_PORTS = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`RHGS_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [`RHGS_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic switching_mode_select,
    input wire logic [`RHGS_MASK_W-1:0] port_power_mask,
    input wire logic overcurrent_per_port,
    input wire logic [`RHGS_MASK_W-1:0] connect_status_change,
    input wire logic bus_suspended,
    input wire logic resume_request,
    input wire logic [`RHGS_MASK_W-1:0] port_power_status
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    localparam logic [15:0] PORTS = 16'((1 << (NUM_PORTS + 1)) - 2);
    logic wr_hub;
    logic rd_hub;
    logic any_conn;
    logic [15:0] eff;
    // Mask only matters in per-port mode
    assign eff = switching_mode_select ? port_power_mask : 16'h0000;
    assign wr_hub = awvalid && awready && wvalid && wready && wstrb == 4'hf
        && awaddr == `RHGS_OFF_HUB_STATUS;
    assign rd_hub = arvalid && arready && araddr == `RHGS_OFF_HUB_STATUS;
    assign any_conn = |connect_status_change;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence on_s;
        wr_hub && wdata[16] && !wdata[0];
    endsequence
    sequence off_s;
        wr_hub && wdata[0];
    endsequence
    sequence pp_rd_s;
        overcurrent_per_port [*4] ##0 rd_hub;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    pwr_on_a: assert property (on_s |=>
        (port_power_status & PORTS & ~$past(eff)) == (PORTS & ~$past(eff)))
        else $error("power on missed a target port");
    pwr_off_a: assert property (off_s |=>
        (port_power_status & PORTS & ~$past(eff)) == 16'h0000)
        else $error("power off missed a target port");
    mask_keep_a: assert property (wr_hub |=>
        (port_power_status & $past(eff)) == ($past(port_power_status) & $past(eff)))
        else $error("masked port changed on global command");
    zero_cmd_a: assert property (wr_hub && !wdata[16] && !wdata[0] |=>
        $stable(port_power_status))
        else $error("power changed without a command");
    no_port_a: assert property ((port_power_status & ~PORTS) == 16'h0000)
        else $error("absent or reserved port powered");
    hub_fmt_a: assert property (rd_hub |=> (rdata & 32'hfffd_7ffd) == 32'h0)
        else $error("hub status read shows a bit that must be zero");
    pp_oc_a: assert property (pp_rd_s |=> !rdata[1])
        else $error("indicator set with per-port reporting");
    wake_src_a: assert property (resume_request |->
        $past(bus_suspended) && $past(any_conn))
        else $error("resume without suspend and connect change");
endmodule

bind rhgs_top rhgs_sva #(.NUM_PORTS(NUM_PORTS)) i_sva (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .switching_mode_select(switching_mode_select), .port_power_mask(port_power_mask),
    .overcurrent_per_port(overcurrent_per_port),
    .connect_status_change(connect_status_change), .bus_suspended(bus_suspended),
    .resume_request(resume_request), .port_power_status(port_power_status)
);
`default_nettype wire

// ==== verification/rhgs_port_model.sv ====
// Downstream port side: over-current pin, connect events, suspend state
`timescale 1ns/1ns
`default_nettype none

module rhgs_port_model (
    input wire logic aclk,
    input wire logic [15:0] port_power_status,
    input wire logic oc_fault,
    input wire logic plug,
    input wire logic suspend,
    output logic overcurrent_field,
    output logic [15:0] connect_status_change,
    output logic bus_suspended
);
    initial connect_status_change = 16'h0000;
    initial bus_suspended = 1'b0;
    initial overcurrent_field = 1'b0;
    // The pin is asynchronous, so it moves well away from the clock edge
    always @(oc_fault) overcurrent_field <= #7 oc_fault;
    // Only a powered port can report a plug, one cycle on the lowest one
    always @(posedge aclk) begin
        connect_status_change <= plug ? (port_power_status & -port_power_status) : 16'h0000;
        bus_suspended <= suspend;
    end
endmodule
`default_nettype wire

// ==== verification/tb_root_hub_global_status.sv ====
// Self-checking bench for the root hub global status block
`timescale 1ns/1ns
`default_nettype none
`include "rhgs_params.svh"

module tb_root_hub_global_status;
    localparam logic [15:0] ALL = 16'h001e;
    localparam logic [1:0] OK = `RHGS_RESP_OKAY;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, irq, res_req, mode, per_port, oc_fault, plug, susp, ocf, bsus;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, cmd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] mask, pps, csc, m, exp;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [7:0] offs[6] = '{8'h50, 8'h54, 8'h58, 8'h60, 8'h64, 8'h68};
    int n_mismatch, check_count, n_res;

    rhgs_top #(.NUM_PORTS(4)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .switching_mode_select(mode),
        .port_power_mask(mask), .overcurrent_per_port(per_port), .overcurrent_field(ocf),
        .connect_status_change(csc), .bus_suspended(bsus), .resume_request(res_req),
        .port_power_status(pps), .irq(irq)
    );
    rhgs_port_model i_ports (
        .aclk(aclk), .port_power_status(pps), .oc_fault(oc_fault), .plug(plug),
        .suspend(susp), .overcurrent_field(ocf), .connect_status_change(csc),
        .bus_suspended(bsus)
    );

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Address and data go out together; each is dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        exp_b.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        // Ready stays high so a back-to-back call never toggles it twice in one step
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
    endtask
    task automatic pw(input logic [15:0] e);
        rd(8'h68, {18'h0, e});
        cmp("power", {18'h0, e}, {18'h0, pps});
    endtask
    task automatic chk_irq(input logic e);
        cmp("irq", {33'h0, e}, {33'h0, irq});
    endtask

    // Results are matched in arrival order against the driver's notes
    always @(posedge aclk) begin
        if (rvalid && rready) cmp("read", exp_r.pop_front(), {rresp, rdata});
        if (bvalid && bready) cmp("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
        if (res_req) n_res++;
    end

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hd452b82b));
        {aresetn, awvalid, wvalid, bready, arvalid, rready, mode, per_port, oc_fault} = '0;
        {plug, susp, awaddr, araddr, wdata, mask} = '0;
        wstrb = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (offs[i]) rd(offs[i], 34'h0);
        // Unmapped place refuses and leaves power alone
        wr(8'h70, 32'h0001_0000, `RHGS_RESP_SLVERR);
        rd(8'h70, {`RHGS_RESP_SLVERR, 32'h0});
        pw(16'h0);
        // Wake enable: set, zero write, clear beating set, plain clear
        wr(8'h50, 32'h0000_8000, OK);
        rd(8'h50, 34'h0_0000_8000);
        wr(8'h50, 32'h0, OK);
        rd(8'h50, 34'h0_0000_8000);
        wr(8'h50, 32'h8000_8000, OK);
        rd(8'h50, 34'h0);
        wr(8'h50, 32'h0000_8000, OK);
        wr(8'h50, 32'h8000_0000, OK);
        rd(8'h50, 34'h0);
        // Global mode ignores a random mask
        mask <= 16'($urandom);
        wr(8'h50, 32'h0001_0000, OK);
        pw(ALL);
        wr(8'h50, 32'h0, OK);
        pw(ALL);
        wr(8'h50, 32'h0000_0001, OK);
        pw(16'h0);
        // Per-port mode: random masks and commands, both bits at the end
        mode <= 1'b1;
        exp = 16'h0;
        for (int i = 0; i < 9; i++) begin
            m = 16'($urandom);
            cmd = (i == 8) ? 32'h0001_0001 : ($urandom & 1) ? 32'h0001_0000 : 32'h1;
            mask <= m;
            wr(8'h50, cmd, OK);
            exp = cmd[0] ? (exp & ~(ALL & ~m)) : (exp | (ALL & ~m));
            pw(exp);
        end
        mode <= 1'b0;
        wr(8'h50, 32'h0001_0000, OK);
        // Over-current rise, flag clears, then fall
        oc_fault <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(8'h50, 34'h0_0002_0002);
        rd(8'h60, 34'h1);
        chk_irq(1'b0);
        wr(8'h64, 32'h3, OK);
        rd(8'h64, 34'h3);
        chk_irq(1'b1);
        wr(8'h50, 32'h0002_0000, OK);
        rd(8'h50, 34'h0_0000_0002);
        wr(8'h60, 32'h1, OK);
        chk_irq(1'b0);
        oc_fault <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(8'h50, 34'h0_0002_0000);
        wr(8'h50, 32'h0002_0000, OK);
        wr(8'h60, 32'h3, OK);
        per_port <= 1'b1;
        oc_fault <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(8'h50, 34'h0);
        // Connect change in suspend: ignored, then a wake event once enabled
        susp <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            plug <= 1'b1;
            @(posedge aclk);
            plug <= 1'b0;
            repeat (4) @(posedge aclk);
            rd(8'h60, {32'h0, 1'(k), 1'b0});
            cmp("resume", 34'(k), 34'(n_res));
            chk_irq(1'(k));
            wr(8'h50, 32'h0000_8000, OK);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
